// ==== msl_mac_stats.v ====
/*
  MAC statistics counters and registered-device list, read by a management
  entity through get and list-get requests. Assumes event pulses and list
  updates come from MAC logic on core_clk; management requests are also
  synchronous to core_clk and are one-cycle pulses.
  Every answer is registered and appears exactly one cycle after its
  request. Status and data stand until the next answer, so a slow reader
  may sample them late. Only the confirm pulse must be caught on time.
  The list has a fixed depth; slot management belongs to the MAC logic.
*/
`timescale 1ns/1ps
`default_nettype none
`include "msl_defines.vh"

module msl_mac_stats (
  input wire core_clk,
  input wire reset,
  // MAC event pulses
  input wire ev_tx_data_ok,
  input wire ev_rx_data_ok,
  input wire ev_rx_data_for_me,
  input wire ev_tx_ctrl_ok,
  input wire ev_rx_ctrl_ok,
  input wire ev_rx_ctrl_for_me,
  input wire ev_cs_fail,
  input wire ev_ch_busy_backoff,
  // Node role and list maintenance from MAC logic
  input wire is_base_node,
  input wire entry_update,
  input wire entry_remove,
  input wire [2:0] entry_index,
  input wire [47:0] entry_device_address,
  input wire [15:0] entry_local_node_identifier,
  input wire entry_is_switch,
  input wire [15:0] entry_local_switch_identifier,
  input wire [15:0] entry_switch_identifier,
  input wire [7:0] entry_hierarchy_level,
  input wire [7:0] entry_terminal_capabilities,
  input wire [7:0] entry_switching_capabilities,
  // Management get request
  input wire management_get_request,
  input wire management_set_request,
  input wire [15:0] attribute_identifier,
  output reg get_confirm_reg,
  output reg [1:0] get_status_reg,
  output reg [31:0] get_value_reg,
  // Management list-get request
  input wire management_list_read_request,
  input wire management_list_write_request,
  input wire [15:0] list_identifier,
  input wire [2:0] list_entry_index,
  output reg list_confirm_reg,
  output reg [1:0] list_status_reg,
  output reg list_valid_reg,
  output reg [47:0] list_device_address_reg,
  output reg [15:0] list_local_node_identifier_reg,
  output reg [7:0] list_functional_state_reg,
  output reg [15:0] list_local_switch_identifier_reg,
  output reg [15:0] list_switch_identifier_reg,
  output reg [7:0] list_hierarchy_level_reg,
  output reg [7:0] list_terminal_capabilities_reg,
  output reg [7:0] list_switching_capabilities_reg
);

  // Counter increment pulses; received traffic for other nodes is dropped
  wire [`MSL_NUM_COUNTERS-1:0] count_event;
  assign count_event[0] = ev_tx_data_ok;
  assign count_event[1] = ev_rx_data_ok & ev_rx_data_for_me;
  assign count_event[2] = ev_tx_ctrl_ok;
  assign count_event[3] = ev_rx_ctrl_ok & ev_rx_ctrl_for_me;
  assign count_event[4] = ev_cs_fail;
  assign count_event[5] = ev_ch_busy_backoff;

  reg [31:0] count_reg [0:`MSL_NUM_COUNTERS-1];

  // One counter per event; wraps naturally through 32-bit addition
  genvar gi;
  generate
    for (gi = 0; gi < `MSL_NUM_COUNTERS; gi = gi + 1) begin : g_cnt
      always @(posedge core_clk) begin
        if (reset) begin
          count_reg[gi] <= `MSL_COUNT_RESET;
        end else if (count_event[gi]) begin
          count_reg[gi] <= count_reg[gi] + 32'h00000001;
        end
      end
    end
  endgenerate

  // Map an attribute identifier to a counter index, flag if mapped
  function [3:0] attr_decode;
    input [15:0] id;
    reg [15:0] off;
    begin
      off = id - `MSL_ATTR_FIRST;
      if (id >= `MSL_ATTR_TX_DATA && id <= `MSL_ATTR_CH_BUSY) begin
        attr_decode = {1'b1, off[2:0]};
      end else begin
        attr_decode = 4'h0;
      end
    end
  endfunction

  wire [3:0] attr_hit = attr_decode(attribute_identifier);

  // Functional state code of a stored entry
  function [7:0] state_code;
    input is_switch;
    begin
      if (is_switch) begin
        state_code = `MSL_STATE_SWITCH;
      end else begin
        state_code = `MSL_STATE_TERMINAL;
      end
    end
  endfunction

  // Next values of the get answer; a set beats a get in the same cycle
  reg get_confirm_next;
  reg [1:0] get_status_next;
  reg [31:0] get_value_next;

  always @* begin
    get_confirm_next = management_get_request | management_set_request;
    get_status_next = get_status_reg;
    get_value_next = get_value_reg;
    if (management_set_request) begin
      get_status_next = `MSL_STATUS_READ_ONLY;
      get_value_next = `MSL_COUNT_RESET;
    end else if (management_get_request) begin
      if (attr_hit[3]) begin
        get_status_next = `MSL_STATUS_OK;
        get_value_next = count_reg[attr_hit[2:0]];
      end else begin
        get_status_next = `MSL_STATUS_UNKNOWN;
        get_value_next = `MSL_COUNT_RESET;
      end
    end
  end

  // Get answer registers; status and value hold until the next answer
  always @(posedge core_clk) begin
    if (reset) begin
      get_confirm_reg <= 1'b0;
      get_status_reg <= `MSL_STATUS_OK;
      get_value_reg <= `MSL_COUNT_RESET;
    end else begin
      get_confirm_reg <= get_confirm_next;
      get_status_reg <= get_status_next;
      get_value_reg <= get_value_next;
    end
  end

  // Registered-device list storage, flip-flops indexed by entry
  reg [`MSL_LIST_DEPTH-1:0] ent_valid_reg;
  reg [47:0] ent_addr_reg [0:`MSL_LIST_DEPTH-1];
  reg [15:0] ent_local_node_identifier_reg [0:`MSL_LIST_DEPTH-1];
  reg [7:0] ent_state_reg [0:`MSL_LIST_DEPTH-1];
  reg [15:0] ent_local_switch_identifier_reg [0:`MSL_LIST_DEPTH-1];
  reg [15:0] ent_sid_reg [0:`MSL_LIST_DEPTH-1];
  reg [7:0] ent_level_reg [0:`MSL_LIST_DEPTH-1];
  reg [7:0] ent_tcap_reg [0:`MSL_LIST_DEPTH-1];
  reg [7:0] ent_swcap_reg [0:`MSL_LIST_DEPTH-1];

  // List is kept only while acting as base node; leaving the role empties it
  generate
    for (gi = 0; gi < `MSL_LIST_DEPTH; gi = gi + 1) begin : g_ent
      always @(posedge core_clk) begin
        if (reset || !is_base_node) begin
          ent_valid_reg[gi] <= 1'b0;
          ent_addr_reg[gi] <= 48'h000000000000;
          ent_local_node_identifier_reg[gi] <= 16'h0000;
          ent_state_reg[gi] <= 8'h00;
          ent_local_switch_identifier_reg[gi] <= 16'h0000;
          ent_sid_reg[gi] <= 16'h0000;
          ent_level_reg[gi] <= 8'h00;
          ent_tcap_reg[gi] <= 8'h00;
          ent_swcap_reg[gi] <= 8'h00;
        end else if (entry_index == gi) begin
          if (entry_update) begin
            ent_valid_reg[gi] <= 1'b1;
            ent_addr_reg[gi] <= entry_device_address;
            ent_local_node_identifier_reg[gi] <= entry_local_node_identifier;
            ent_state_reg[gi] <= state_code(entry_is_switch);
            ent_local_switch_identifier_reg[gi] <= entry_local_switch_identifier;
            ent_sid_reg[gi] <= entry_switch_identifier;
            ent_level_reg[gi] <= entry_hierarchy_level;
            // Reserved bits are forced low so they always read zero
            ent_tcap_reg[gi] <=
              entry_terminal_capabilities & `MSL_TCAP_MASK;
            ent_swcap_reg[gi] <=
              entry_switching_capabilities & `MSL_SWCAP_MASK;
          end else if (entry_remove) begin
            ent_valid_reg[gi] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  wire list_known = (list_identifier == `MSL_LIST_REG_DEVICES);
  wire list_hit = list_known && is_base_node &&
    ent_valid_reg[list_entry_index];

  // Entry picked by the list read, looked up once for every field
  wire [47:0] sel_addr = ent_addr_reg[list_entry_index];
  wire [15:0] sel_local_node_identifier = ent_local_node_identifier_reg[list_entry_index];
  wire [7:0] sel_state = ent_state_reg[list_entry_index];
  wire [15:0] sel_local_switch_identifier = ent_local_switch_identifier_reg[list_entry_index];
  wire [15:0] sel_sid = ent_sid_reg[list_entry_index];
  wire [7:0] sel_level = ent_level_reg[list_entry_index];
  wire [7:0] sel_tcap = ent_tcap_reg[list_entry_index];
  wire [7:0] sel_swcap = ent_swcap_reg[list_entry_index];

  // Next values of the list answer; fields keep the last good entry
  reg list_confirm_next;
  reg [1:0] list_status_next;
  reg list_valid_next;
  reg [47:0] list_device_address_next;
  reg [15:0] list_local_node_identifier_next;
  reg [7:0] list_functional_state_next;
  reg [15:0] list_local_switch_identifier_next;
  reg [15:0] list_switch_identifier_next;
  reg [7:0] list_hierarchy_level_next;
  reg [7:0] list_terminal_capabilities_next;
  reg [7:0] list_switching_capabilities_next;

  // A write attempt wins over a read and is always refused
  always @* begin
    list_confirm_next = management_list_read_request |
      management_list_write_request;
    list_status_next = list_status_reg;
    list_valid_next = list_valid_reg;
    list_device_address_next = list_device_address_reg;
    list_local_node_identifier_next = list_local_node_identifier_reg;
    list_functional_state_next = list_functional_state_reg;
    list_local_switch_identifier_next = list_local_switch_identifier_reg;
    list_switch_identifier_next = list_switch_identifier_reg;
    list_hierarchy_level_next = list_hierarchy_level_reg;
    list_terminal_capabilities_next = list_terminal_capabilities_reg;
    list_switching_capabilities_next = list_switching_capabilities_reg;
    if (management_list_write_request) begin
      list_status_next = `MSL_STATUS_READ_ONLY;
      list_valid_next = 1'b0;
    end else if (management_list_read_request) begin
      list_valid_next = list_hit;
      if (!list_known) begin
        list_status_next = `MSL_STATUS_UNKNOWN;
      end else if (!list_hit) begin
        list_status_next = `MSL_STATUS_NO_ENTRY;
      end else begin
        list_status_next = `MSL_STATUS_OK;
        list_device_address_next = sel_addr;
        list_local_node_identifier_next = sel_local_node_identifier;
        list_functional_state_next = sel_state;
        list_local_switch_identifier_next = sel_local_switch_identifier;
        list_switch_identifier_next = sel_sid;
        list_hierarchy_level_next = sel_level;
        list_terminal_capabilities_next = sel_tcap;
        list_switching_capabilities_next = sel_swcap;
      end
    end
  end

  // List answer registers, one cycle after the request
  always @(posedge core_clk) begin
    if (reset) begin
      list_confirm_reg <= 1'b0;
      list_status_reg <= `MSL_STATUS_OK;
      list_valid_reg <= 1'b0;
      list_device_address_reg <= 48'h000000000000;
      list_local_node_identifier_reg <= 16'h0000;
      list_functional_state_reg <= 8'h00;
      list_local_switch_identifier_reg <= 16'h0000;
      list_switch_identifier_reg <= 16'h0000;
      list_hierarchy_level_reg <= 8'h00;
      list_terminal_capabilities_reg <= 8'h00;
      list_switching_capabilities_reg <= 8'h00;
    end else begin
      list_confirm_reg <= list_confirm_next;
      list_status_reg <= list_status_next;
      list_valid_reg <= list_valid_next;
      list_device_address_reg <= list_device_address_next;
      list_local_node_identifier_reg <= list_local_node_identifier_next;
      list_functional_state_reg <= list_functional_state_next;
      list_local_switch_identifier_reg <= list_local_switch_identifier_next;
      list_switch_identifier_reg <= list_switch_identifier_next;
      list_hierarchy_level_reg <= list_hierarchy_level_next;
      list_terminal_capabilities_reg <= list_terminal_capabilities_next;
      list_switching_capabilities_reg <= list_switching_capabilities_next;
    end
  end

endmodule
`default_nettype wire

// ==== msl_defines.vh ====
/*
  Constants for the MAC statistics and list management block: attribute
  and list identifiers, list depth, state codes, capability bits.
  Assumes inclusion by bare name from the design file.
*/
`ifndef MSL_DEFINES_VH
`define MSL_DEFINES_VH

// Statistics attribute identifiers
`define MSL_ATTR_TX_DATA 16'h0040
`define MSL_ATTR_RX_DATA 16'h0041
`define MSL_ATTR_TX_CTRL 16'h0042
`define MSL_ATTR_RX_CTRL 16'h0043
`define MSL_ATTR_CS_FAIL 16'h0044
`define MSL_ATTR_CH_BUSY 16'h0045
`define MSL_ATTR_FIRST 16'h0040
`define MSL_NUM_COUNTERS 6
`define MSL_COUNT_RESET 32'h00000000

// List identifiers
`define MSL_LIST_REG_DEVICES 16'h0050

// Functional state encodings
`define MSL_STATE_TERMINAL 8'h01
`define MSL_STATE_SWITCH 8'h02

// Registered-device list depth
`define MSL_LIST_DEPTH 8
`define MSL_LIST_IDX_W 3

// Reserved-bit masks for capability bitmaps
`define MSL_TCAP_MASK 8'h7F
`define MSL_SWCAP_MASK 8'h0F

// Answer status codes
`define MSL_STATUS_OK 2'h0
`define MSL_STATUS_UNKNOWN 2'h1
`define MSL_STATUS_READ_ONLY 2'h2
`define MSL_STATUS_NO_ENTRY 2'h3

`endif

// ==== msl_mac_stats_assertions.sv ====
/* Checker for msl_mac_stats answer timing, refusals and list fields.
   Assumes a single core_clk domain; bound to the design by name. */
`timescale 1ns/1ps
`default_nettype none
module msl_mac_stats_assertions (
  input wire core_clk,
  input wire reset,
  input wire management_get_request,
  input wire management_set_request,
  input wire get_confirm_reg,
  input wire [1:0] get_status_reg,
  input wire management_list_read_request,
  input wire management_list_write_request,
  input wire [15:0] list_identifier,
  input wire is_base_node,
  input wire list_confirm_reg,
  input wire [1:0] list_status_reg,
  input wire list_valid_reg,
  input wire [7:0] list_functional_state_reg,
  input wire [7:0] list_terminal_capabilities_reg,
  input wire [7:0] list_switching_capabilities_reg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  // A list read that reaches a node without the base role
  sequence s_orphan_read;
    management_list_read_request && !management_list_write_request &&
    !is_base_node && list_identifier == 16'h0050;
  endsequence
  sequence s_no_entry;
    list_confirm_reg && list_status_reg == 2'h3 && !list_valid_reg;
  endsequence
  chk_get_answer: assert property ((management_get_request ||
    management_set_request) |=> get_confirm_reg) else $error("no answer");
  chk_get_cause: assert property (get_confirm_reg |->
    $past(management_get_request || management_set_request))
    else $error("answer without request");
  chk_set_refused: assert property (management_set_request |=>
    get_status_reg == 2'h2) else $error("counter write not refused");
  chk_list_refused: assert property (management_list_write_request |=>
    list_confirm_reg && list_status_reg == 2'h2 && !list_valid_reg)
    else $error("list write not refused");
  chk_not_base: assert property (s_orphan_read |=> s_no_entry)
    else $error("list served without base role");
  chk_state_code: assert property (list_valid_reg |->
    list_functional_state_reg inside {8'h01, 8'h02}) else $error("bad state");
  chk_tcap_rsvd: assert property (!list_terminal_capabilities_reg[7])
    else $error("terminal reserved bit set");
  chk_swcap_rsvd: assert property (
    list_switching_capabilities_reg[7:4] == 4'h0)
    else $error("switching reserved bits set");
endmodule
bind msl_mac_stats msl_mac_stats_assertions i_msl_mac_stats_assertions (
  .core_clk(core_clk), .reset(reset),
  .management_get_request(management_get_request),
  .management_set_request(management_set_request),
  .get_confirm_reg(get_confirm_reg), .get_status_reg(get_status_reg),
  .management_list_read_request(management_list_read_request),
  .management_list_write_request(management_list_write_request),
  .list_identifier(list_identifier), .is_base_node(is_base_node),
  .list_confirm_reg(list_confirm_reg), .list_status_reg(list_status_reg),
  .list_valid_reg(list_valid_reg),
  .list_functional_state_reg(list_functional_state_reg),
  .list_terminal_capabilities_reg(list_terminal_capabilities_reg),
  .list_switching_capabilities_reg(list_switching_capabilities_reg));
`default_nettype wire

// ==== msl_mgmt_model.sv ====
/* Management entity model: turns bench commands into one-cycle requests.
   Assumes commands change just after a core_clk rising edge. */
`timescale 1ns/1ps
`default_nettype none
module msl_mgmt_model (
  input wire logic core_clk,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [15:0] cmd_id,
  output var logic [3:0] req = 4'h0,
  output var logic [15:0] id_out = 16'h0000
);
  // One pulse per command; idle ids toggle so a stale id recurs only every other cycle
  always @(posedge core_clk) begin
    req <= cmd_valid ? 4'h1 << cmd_kind : 4'h0;
    id_out <= cmd_valid ? cmd_id : ~id_out;
  end
endmodule
`default_nettype wire

// ==== msl_mac_stats_tb.sv ====
/* Self-checking bench for msl_mac_stats: event bursts, counter and list
   reads, refusals. Assumes msl_mgmt_model and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module msl_mac_stats_tb;
  logic core_clk = 1'b0, reset = 1'b1, base = 1'b0, upd = 1'b0, cv = 1'b0;
  logic [7:0] ev = 8'h00;
  logic [7:0] masks [6] = '{8'h01, 8'h06, 8'h08, 8'h30, 8'h40, 8'h80};
  logic [1:0] ck = 2'h0;
  logic [15:0] cid = 16'h0000;
  logic [47:0] addr = 48'h0, e;
  logic [130:0] le;
  logic [3:0] req;
  logic [15:0] id;
  wire get_cf, list_cf, lvalid;
  wire [1:0] gst, lst;
  wire [31:0] gval;
  wire [47:0] laddr;
  wire [7:0] lstate, ltcap, lswcap, llvl;
  wire [15:0] local_node_identifier, local_switch_identifier, lsw;
  logic [33:0] gq[$];
  logic [130:0] lq[$];
  int err_count = 0, comparisons = 0, seed = 16, n;
  msl_mgmt_model i_msl_mgmt_model (.core_clk(core_clk), .cmd_valid(cv),
    .cmd_kind(ck), .cmd_id(cid), .req(req), .id_out(id));
  msl_mac_stats i_msl_mac_stats (.core_clk(core_clk), .reset(reset),
    .ev_tx_data_ok(ev[0]), .ev_rx_data_ok(ev[1]), .ev_rx_data_for_me(ev[2]),
    .ev_tx_ctrl_ok(ev[3]), .ev_rx_ctrl_ok(ev[4]), .ev_rx_ctrl_for_me(ev[5]),
    .ev_cs_fail(ev[6]), .ev_ch_busy_backoff(ev[7]), .is_base_node(base),
    .entry_update(upd), .entry_remove(1'b0), .entry_index(3'h3),
    .entry_device_address(addr), .entry_local_node_identifier(addr[15:0]),
    .entry_is_switch(addr[0]), .entry_local_switch_identifier(addr[31:16]),
    .entry_switch_identifier(addr[47:32]), .entry_hierarchy_level(addr[7:0]),
    .entry_terminal_capabilities(addr[47:40]),
    .entry_switching_capabilities(addr[15:8]),
    .management_get_request(req[0]), .management_set_request(req[1]),
    .attribute_identifier(id), .get_confirm_reg(get_cf),
    .get_status_reg(gst), .get_value_reg(gval),
    .management_list_read_request(req[2]),
    .management_list_write_request(req[3]), .list_identifier(id),
    .list_entry_index(3'h3), .list_confirm_reg(list_cf),
    .list_status_reg(lst), .list_valid_reg(lvalid),
    .list_device_address_reg(laddr), .list_local_node_identifier_reg(local_node_identifier),
    .list_functional_state_reg(lstate),
    .list_local_switch_identifier_reg(local_switch_identifier),
    .list_switch_identifier_reg(lsw),
    .list_hierarchy_level_reg(llvl), .list_terminal_capabilities_reg(ltcap),
    .list_switching_capabilities_reg(lswcap));
  initial forever #2.5 core_clk = ~core_clk;
  // Issue one request and note its expected answer
  task automatic ask(input logic [1:0] k, input logic [15:0] a,
                     input logic [130:0] lx, input logic [33:0] gx);
    @(posedge core_clk);
    cv <= 1'b1;
    ck <= k;
    cid <= a;
    if (k[1]) lq.push_back(lx);
    else gq.push_back(gx);
  endtask
  task automatic cmp_get(input logic [33:0] x, input logic [33:0] s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("unexpected get answer: expected %h, seen %h", x, s);
    end
  endtask
  task automatic cmp_list(input logic [130:0] x, input logic [130:0] s);
    comparisons++;
    if (s !== x) begin
      err_count++;
      $display("unexpected list answer: expected %h, seen %h", x, s);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d, err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Confirms stand a full cycle, so the falling edge sees them settled
  always @(negedge core_clk) begin
    if (get_cf === 1'b1) cmp_get(gq.pop_front(), {gst, gval});
    if (list_cf === 1'b1) cmp_list(lq.pop_front(),
      {lst, lvalid, lstate, ltcap, lswcap, laddr, local_node_identifier, local_switch_identifier, lsw, llvl});
  end
  initial begin
    repeat (2000) @(posedge core_clk);
    err_count++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    reset <= 1'b0;
    // Random burst per counter; bare receptions in between must not count
    for (int k = 0; k < 6; k++) begin
      n = 1 + $unsigned($random(seed)) % 8;
      repeat (n) begin
        @(posedge core_clk);
        cv <= 1'b0;
        ev <= masks[k];
        @(posedge core_clk);
        ev <= 8'h12;
      end
      @(posedge core_clk);
      ev <= 8'h00;
      ask(2'h0, 16'h0040 + 16'(k), 75'h0, {2'h0, n});
    end
    ask(2'h1, 16'h0040, 75'h0, 34'h200000000);
    ask(2'h0, 16'h0046, 75'h0, 34'h100000000);
    // Top reserved bit of each capability bitmap forced high to prove it is dropped
    e = {$random(seed), $random(seed)} | 48'h800000008000;
    le = {3'h1, e[0] ? 8'h02 : 8'h01, e[47:40] & 8'h7F, e[15:8] & 8'h0F, e,
      e[15:0], e[31:16], e[47:32], e[7:0]};
    @(posedge core_clk);
    cv <= 1'b0;
    base <= 1'b1;
    upd <= 1'b1;
    addr <= e;
    @(posedge core_clk);
    upd <= 1'b0;
    ask(2'h2, 16'h0050, le, 34'h0);
    ask(2'h3, 16'h0050, {3'h4, le[127:0]}, 34'h0);
    ask(2'h2, 16'h0051, {3'h2, le[127:0]}, 34'h0);
    @(posedge core_clk);
    cv <= 1'b0;
    base <= 1'b0;
    ask(2'h2, 16'h0050, {3'h6, le[127:0]}, 34'h0);
    @(posedge core_clk);
    cv <= 1'b0;
    repeat (6) @(posedge core_clk);
    if (gq.size() + lq.size() != 0) err_count++;
    print_verdict();
  end
endmodule
`default_nettype wire
